// [core/ecpx_consts.svh]
`ifndef ECPX_CONSTS_SVH
`define ECPX_CONSTS_SVH

// host addresses, low 11 bits of the port window
`define ECPX_A_DATA     11'h000
`define ECPX_A_STAT     11'h001
`define ECPX_A_DCR      11'h002
`define ECPX_A_CFGA     11'h400
`define ECPX_A_CFGB     11'h401
`define ECPX_A_EIR      11'h403
`define ECPX_A_EDR      11'h404
`define ECPX_A_AUX      11'h405

// second-level indices
`define ECPX_IX_CTRL0   3'h0
`define ECPX_IX_CTRL2   3'h2
`define ECPX_IX_CTRL4   3'h4
`define ECPX_IX_CFG0    3'h5

// reset values
`define ECPX_RST_CTRL0  8'h00
`define ECPX_RST_CTRL2  8'h00
`define ECPX_RST_CTRL4  8'h07
`define ECPX_RST_CFG0   8'h00
`define ECPX_RST_AUX    8'h00

// writable-bit masks, reserved bits read zero
`define ECPX_MSK_CTRL0  8'h31
`define ECPX_MSK_CTRL2  8'hd8
`define ECPX_MSK_CTRL4  8'h77
`define ECPX_MSK_CFG0   8'hff

// field positions
`define ECPX_B_TMO_EN   0
`define ECPX_B_FREEZE   4
`define ECPX_B_LIVE     5
`define ECPX_B_ZWS17    3
`define ECPX_B_V19      4
`define ECPX_B_CHADR    6
`define ECPX_B_COMPAT   7
`define ECPX_B_DEMAND   6
`define ECPX_B_USER     7
`define ECPX_B_PEPU     2
`define ECPX_B_DIR      5
`define ECPX_B_IRQEN    4

// modes
`define ECPX_M_STD      3'h0
`define ECPX_M_BIDIR    3'h1
`define ECPX_M_ECP      3'h3
`define ECPX_M_EPP      3'h4
`define ECPX_M_CFG      3'h7

// timing
`define ECPX_FLUSH_CLKS 256
`define ECPX_FLUSH_KHZ  24000
`define ECPX_SYS_KHZ    125000
`define ECPX_FLUSH_CYC  ((`ECPX_FLUSH_CLKS * `ECPX_SYS_KHZ) / `ECPX_FLUSH_KHZ)
`define ECPX_DMA_THR    5'h04
`define ECPX_BURST_LEN  2'h3
`define ECPX_REST_BASE  8'h08
`define ECPX_REST_STEP  8'h20
`define ECPX_CFGA_BASE  8'h10

`endif

// [core/ecpx_pkg.sv]
package ecpx_pkg;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [10:0] addr;
        logic [7:0]  wdata;
    } ecpx_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } ecpx_rsp_t;

    typedef enum logic [2:0] {
        ECPX_IDLE = 3'b001,
        ECPX_REQ  = 3'b010,
        ECPX_REST = 3'b100
    } ecpx_dma_st_t;

    typedef struct packed {
        logic [7:0]   ctrl0;
        logic [7:0]   ctrl2;
        logic [7:0]   ctrl4;
        logic [7:0]   cfg0;
        logic [2:0]   ext_index_reg;
        logic [7:0]   pd_m;
        logic [7:0]   pd_s;
        logic [4:0]   stat_m;
        logic [4:0]   stat_s;
        logic [3:0]   ctl_m;
        logic [3:0]   ctl_s;
        logic [2:0]   mode_prev;
        logic         ack_prev;
        logic         irq_flag;
        logic         frz_prev;
        ecpx_rsp_t    rsp;
        logic         zero_wait_state;
        logic         tmo_irq;
        logic         cmd_push;
        logic         frz_reinit;
        logic         irq;
        logic         irq_oe;
        logic         drq;
        ecpx_dma_st_t dst;
        logic [1:0]   burst;
        logic [5:0]   act;
        logic [7:0]   rest;
        logic         flush_run;
        logic [10:0]  flush_cnt;
        logic         flush_exp;
    } ecpx_state_t;

endpackage : ecpx_pkg

// [core/ecpx_regs.sv]
// What this block does
// - only indices 0, 2, 4 and 5 reach a register; other indices do nothing.
// - aux status bit 7 shows the bottom FIFO tag in ECP mode backward.
// - control zero bit 0 lets the EPP time-out interrupt through.
// - freeze bit freezes the interface in ECP mode; clearing it reinitialises.
// - live bit makes control register reads return pin levels.
// - control two bit 3 enables zero-wait-state on EPP 1.7 accesses.
// - no zero-wait-state on SPP or EPP 1.9; always on ECP.
// - control two bit 4 selects EPP 1.7 or 1.9.
// - backward ECP command bytes with data bit 7 are pushed when enabled.
// - compatibility bit turns modes 000, 001, 100 into legacy behaviour.
// - legacy modes read control pins 3-0; modes 000/001 read bit 5 as 1.
// - legacy data reads return the latch in mode 000 or forward 001/100.
// - legacy modes float the interrupt when control bit 4 is 0.
// - legacy mode 001 interrupt is a level set by ACK trailing edge, in status bit 2.
// - DMA active limit is one transfer for 0, else 4(n+1) transfers.
// - after a fairness drop the request stays low 8 + 32n clocks.
// - port config zero reports DMA and IRQ numbers in configuration B view.
// - demand DMA raises the request at threshold four or flush time-out.
// - request holds for bursts of four while FIFO and fairness allow.
// - flush time-out of 256 reference clocks starts on backward byte write.
// - flush counter clears on request, forward direction or demand disabled.
// - any mode change resets the demand DMA and flush mechanism.
// - port config zero bit 7 is mirrored to configuration A bit 3.
`include "ecpx_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ecpx_regs (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_b_i,
    input  wire ecpx_pkg::ecpx_req_t host_req_i,
    output var  ecpx_pkg::ecpx_rsp_t host_rsp_o,
    input  wire logic [2:0]       mode_i,
    input  wire logic [7:0]       dcr_stored_i,
    input  wire logic [7:0]       data_latch_i,
    input  wire logic [7:0]       pd_pins_i,
    input  wire logic [3:0]       ctl_pins_i,
    input  wire logic [4:0]       stat_pins_i,
    input  wire logic             fifo_tag_i,
    input  wire logic [4:0]       fifo_free_i,
    input  wire logic [4:0]       fifo_valid_i,
    input  wire logic             dma_en_i,
    input  wire logic             svc_intr_i,
    input  wire logic             xfer_done_i,
    input  wire logic             per_byte_wr_i,
    input  wire logic             per_cmd_stb_i,
    input  wire logic             epp_acc_i,
    input  wire logic             ecp_acc_i,
    input  wire logic             epp_tmo_i,
    input  wire logic             core_irq_i,
    output logic                  zws_o,
    output logic                  epp_tmo_irq_o,
    output logic                  epp_v19_o,
    output logic                  freeze_o,
    output logic                  freeze_reinit_o,
    output logic                  cmd_push_o,
    output logic                  compat_o,
    output logic                  pe_pullup_o,
    output logic                  pp_irq_o,
    output logic                  pp_irq_oe_o,
    output logic                  drq_o
);

    ////////////////////////////////////////////////////////////////////////////////
    logic                  rst_m_q;
    logic                  rst_s_q;
    ecpx_pkg::ecpx_state_t st_q;
    ecpx_pkg::ecpx_state_t st_d;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [5:0] act_limit(input logic [2:0] n);
        if (n == 3'h0) begin
            act_limit = 6'h01;
        end else begin
            act_limit = {1'b0, n, 2'b00} + 6'h04;
        end
    endfunction : act_limit

    function automatic logic [7:0] rest_len(input logic [2:0] n);
        rest_len = `ECPX_REST_BASE + (`ECPX_REST_STEP * {5'h00, n});
    endfunction : rest_len

    function automatic logic legacy_mode(input logic [2:0] m, input logic compat);
        legacy_mode = compat && (m == `ECPX_M_STD || m == `ECPX_M_BIDIR || m == `ECPX_M_EPP);
    endfunction : legacy_mode

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [10:0] FLUSH_LAST = 11'(`ECPX_FLUSH_CYC - 1);

    logic       is_ecp;
    logic       dir_back;
    logic       legacy;
    logic       demand;
    logic       mode_chg;
    logic       thr_ok;
    logic       can_serve;
    logic       blocked;
    logic       frz_eff;
    logic [7:0] edr_rd;
    logic [7:0] dcr_rd;
    logic [7:0] data_rd;
    logic [7:0] rd_mux;
    logic [7:0] wmask;

    always_comb begin
        st_d      = st_q;
        is_ecp    = (mode_i == `ECPX_M_ECP);
        dir_back  = is_ecp && dcr_stored_i[`ECPX_B_DIR];
        legacy    = legacy_mode(mode_i, st_q.ctrl2[`ECPX_B_COMPAT]);
        demand    = st_q.cfg0[`ECPX_B_DEMAND];
        mode_chg  = (mode_i != st_q.mode_prev);
        thr_ok    = dir_back ? (fifo_valid_i >= `ECPX_DMA_THR) : (fifo_free_i >= `ECPX_DMA_THR);
        can_serve = dir_back ? (fifo_valid_i != 5'h00) : (fifo_free_i != 5'h00);
        blocked   = !dma_en_i || svc_intr_i;
        frz_eff   = is_ecp && st_q.ctrl0[`ECPX_B_FREEZE];
        wmask     = 8'h00;

        // input synchronisers, first stage read only by the second
        st_d.pd_m   = pd_pins_i;
        st_d.pd_s   = st_q.pd_m;
        st_d.stat_m = stat_pins_i;
        st_d.stat_s = st_q.stat_m;
        st_d.ctl_m  = ctl_pins_i;
        st_d.ctl_s  = st_q.ctl_m;
        st_d.mode_prev = mode_i;

        ////////////////////////////////////////////////////////////////////////////
        // data window read, unknown index answers zero
        case (st_q.ext_index_reg)
            `ECPX_IX_CTRL0: edr_rd = st_q.ctrl0;
            `ECPX_IX_CTRL2: edr_rd = st_q.ctrl2;
            `ECPX_IX_CTRL4: edr_rd = st_q.ctrl4;
            `ECPX_IX_CFG0:  edr_rd = st_q.cfg0;
            default:        edr_rd = 8'h00;
        endcase

        dcr_rd = dcr_stored_i;
        if (st_q.ctrl0[`ECPX_B_LIVE] || legacy) begin
            dcr_rd[3:0] = st_q.ctl_s;
        end
        if (legacy && (mode_i == `ECPX_M_STD || mode_i == `ECPX_M_BIDIR)) begin
            dcr_rd[`ECPX_B_DIR] = 1'b1;
        end

        if (legacy) begin
            data_rd = (mode_i == `ECPX_M_STD || !dcr_stored_i[`ECPX_B_DIR])
                      ? data_latch_i : st_q.pd_s;
        end else begin
            data_rd = dcr_stored_i[`ECPX_B_DIR] ? st_q.pd_s : data_latch_i;
        end

        case (host_req_i.addr)
            `ECPX_A_DATA: rd_mux = data_rd;
            `ECPX_A_STAT: rd_mux = {st_q.stat_s, st_q.irq_flag, 2'b00};
            `ECPX_A_DCR:  rd_mux = dcr_rd;
            `ECPX_A_CFGA: rd_mux = (mode_i == `ECPX_M_CFG)
                                   ? (`ECPX_CFGA_BASE | {4'h0, st_q.cfg0[`ECPX_B_USER], 3'h0})
                                   : 8'h00;
            `ECPX_A_CFGB: rd_mux = (mode_i == `ECPX_M_CFG)
                                   ? {1'b0, st_q.irq, st_q.cfg0[5:3], 1'b0, st_q.cfg0[1:0]}
                                   : 8'h00;
            `ECPX_A_EIR:  rd_mux = {5'h00, st_q.ext_index_reg};
            `ECPX_A_EDR:  rd_mux = edr_rd;
            `ECPX_A_AUX:  rd_mux = (is_ecp && dir_back)
                                   ? {fifo_tag_i, 7'h00} : `ECPX_RST_AUX;
            default:      rd_mux = 8'h00;
        endcase
        st_d.rsp.valid = host_req_i.rd;
        st_d.rsp.data  = host_req_i.rd ? rd_mux : 8'h00;

        ////////////////////////////////////////////////////////////////////////////
        // writes through index and data window
        if (host_req_i.wr && host_req_i.addr == `ECPX_A_EIR) begin
            st_d.ext_index_reg = host_req_i.wdata[2:0];
        end
        if (host_req_i.wr && host_req_i.addr == `ECPX_A_EDR) begin
            case (st_q.ext_index_reg)
                `ECPX_IX_CTRL0: begin
                    wmask      = `ECPX_MSK_CTRL0;
                    st_d.ctrl0 = host_req_i.wdata & wmask;
                end
                `ECPX_IX_CTRL2: begin
                    wmask      = `ECPX_MSK_CTRL2;
                    st_d.ctrl2 = host_req_i.wdata & wmask;
                end
                `ECPX_IX_CTRL4: begin
                    wmask      = `ECPX_MSK_CTRL4;
                    st_d.ctrl4 = host_req_i.wdata & wmask;
                end
                `ECPX_IX_CFG0: begin
                    wmask     = `ECPX_MSK_CFG0;
                    st_d.cfg0 = host_req_i.wdata & wmask;
                end
                default: begin
                    wmask = 8'h00;
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////////////
        // port side controls
        st_d.zero_wait_state = ecp_acc_i
                 || (epp_acc_i && !st_q.ctrl2[`ECPX_B_V19] && st_q.ctrl2[`ECPX_B_ZWS17]);
        st_d.tmo_irq    = epp_tmo_i && st_q.ctrl0[`ECPX_B_TMO_EN];
        st_d.frz_prev   = frz_eff;
        st_d.frz_reinit = st_q.frz_prev && !frz_eff && is_ecp;
        st_d.cmd_push   = per_cmd_stb_i && st_q.ctrl2[`ECPX_B_CHADR] && dir_back
                        && !st_q.stat_s[4] && st_q.pd_s[7];

        // ack trailing edge sets the level; set wins over the status-read clear
        st_d.ack_prev = st_q.stat_s[3];
        if (host_req_i.rd && host_req_i.addr == `ECPX_A_STAT) begin
            st_d.irq_flag = 1'b0;
        end
        if (legacy && mode_i == `ECPX_M_BIDIR && st_q.stat_s[3] && !st_q.ack_prev) begin
            st_d.irq_flag = 1'b1;
        end
        if (legacy) begin
            st_d.irq    = (mode_i == `ECPX_M_BIDIR) ? st_q.irq_flag : core_irq_i;
            st_d.irq_oe = dcr_stored_i[`ECPX_B_IRQEN];
        end else begin
            st_d.irq    = core_irq_i;
            st_d.irq_oe = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////////////
        // flush time-out, backward demand mode only
        if (!demand || !dir_back || st_q.drq) begin
            st_d.flush_run = 1'b0;
            st_d.flush_cnt = 11'h000;
            if (st_q.drq || !demand || !dir_back) begin
                st_d.flush_exp = 1'b0;
            end
        end else if (st_q.flush_run) begin
            if (st_q.flush_cnt == FLUSH_LAST) begin
                st_d.flush_run = 1'b0;
                st_d.flush_exp = 1'b1;
                st_d.flush_cnt = 11'h000;
            end else begin
                st_d.flush_cnt = st_q.flush_cnt + 11'h001;
            end
        end else if (per_byte_wr_i) begin
            st_d.flush_run = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////////////
        // request pacing
        case (st_q.dst)
            ecpx_pkg::ECPX_IDLE: begin
                st_d.drq   = 1'b0;
                st_d.burst = 2'h0;
                st_d.act   = 6'h00;
                if (!blocked && !mode_chg) begin
                    if (demand ? (thr_ok || st_q.flush_exp) : can_serve) begin
                        st_d.dst = ecpx_pkg::ECPX_REQ;
                        st_d.drq = 1'b1;
                    end
                end
            end
            ecpx_pkg::ECPX_REQ: begin
                if (blocked) begin
                    st_d.dst = ecpx_pkg::ECPX_IDLE;
                    st_d.drq = 1'b0;
                end else if (xfer_done_i) begin
                    st_d.act = st_q.act + 6'h01;
                    st_d.burst = st_q.burst + 2'h1;
                    if (st_q.act + 6'h01 >= act_limit(st_q.ctrl4[2:0])) begin
                        st_d.dst  = ecpx_pkg::ECPX_REST;
                        st_d.drq  = 1'b0;
                        // the idle state after the rest adds one more low cycle
                        st_d.rest = rest_len(st_q.ctrl4[6:4]) - 8'h02;
                    end else if (demand && st_q.burst == `ECPX_BURST_LEN && !thr_ok) begin
                        st_d.dst = ecpx_pkg::ECPX_IDLE;
                        st_d.drq = 1'b0;
                    end
                end else if (!can_serve) begin
                    st_d.dst = ecpx_pkg::ECPX_IDLE;
                    st_d.drq = 1'b0;
                end
            end
            ecpx_pkg::ECPX_REST: begin
                st_d.drq = 1'b0;
                if (st_q.rest == 8'h00) begin
                    st_d.dst = ecpx_pkg::ECPX_IDLE;
                end else begin
                    st_d.rest = st_q.rest - 8'h01;
                end
            end
            default: begin
                st_d.dst = ecpx_pkg::ECPX_IDLE;
                st_d.drq = 1'b0;
            end
        endcase

        // a new mode drops the request, restarts pacing and clears the flush time-out
        if (mode_chg) begin
            st_d.dst       = ecpx_pkg::ECPX_IDLE;
            st_d.drq       = 1'b0;
            st_d.burst     = 2'h0;
            st_d.act       = 6'h00;
            st_d.rest      = 8'h00;
            st_d.flush_run = 1'b0;
            st_d.flush_cnt = 11'h000;
            st_d.flush_exp = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_i or negedge rst_s_q) begin
        if (!rst_s_q) begin
            st_q       <= '0;
            st_q.ctrl0 <= `ECPX_RST_CTRL0;
            st_q.ctrl2 <= `ECPX_RST_CTRL2;
            st_q.ctrl4 <= `ECPX_RST_CTRL4;
            st_q.cfg0  <= `ECPX_RST_CFG0;
            st_q.dst   <= ecpx_pkg::ECPX_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign host_rsp_o      = st_q.rsp;
    assign zws_o           = st_q.zero_wait_state;
    assign epp_tmo_irq_o   = st_q.tmo_irq;
    assign epp_v19_o       = st_q.ctrl2[`ECPX_B_V19];
    assign freeze_o        = st_q.frz_prev;
    assign freeze_reinit_o = st_q.frz_reinit;
    assign cmd_push_o      = st_q.cmd_push;
    assign compat_o        = st_q.ctrl2[`ECPX_B_COMPAT];
    assign pe_pullup_o     = st_q.cfg0[`ECPX_B_PEPU];
    assign pp_irq_o        = st_q.irq;
    assign pp_irq_oe_o     = st_q.irq_oe;
    assign drq_o           = st_q.drq;

endmodule : ecpx_regs

`default_nettype wire

// [sim/ecpx_regs_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module ecpx_regs_properties (
    input wire logic                sys_clk_i,
    input wire logic                rst_b_i,
    input wire ecpx_pkg::ecpx_req_t host_req_i,
    input wire ecpx_pkg::ecpx_rsp_t host_rsp_o,
    input wire logic [2:0]          mode_i,
    input wire logic                dma_en_i,
    input wire logic                svc_intr_i,
    input wire logic                epp_acc_i,
    input wire logic                ecp_acc_i,
    input wire logic                epp_tmo_i,
    input wire logic                zws_o,
    input wire logic                epp_tmo_irq_o,
    input wire logic                epp_v19_o,
    input wire logic                freeze_o,
    input wire logic                cmd_push_o,
    input wire logic                drq_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    a_rd_answered: assert property (host_req_i.rd |=> host_rsp_o.valid)
        else $error("read not answered one cycle later");
    a_idle_data_zero: assert property (!host_rsp_o.valid |-> host_rsp_o.data == 8'h00)
        else $error("read data not zero outside a reply");
    a_zws_on_ecp: assert property (ecp_acc_i |=> zws_o)
        else $error("zero-wait-state missing on ecp access");
    a_zws_not_v19: assert property (epp_acc_i && epp_v19_o && !ecp_acc_i |=> !zws_o)
        else $error("zero-wait-state on newer epp access");
    a_zws_no_cause: assert property (!epp_acc_i && !ecp_acc_i |=> !zws_o)
        else $error("zero-wait-state without an access");
    a_v19_by_write: assert property ($changed(epp_v19_o) |-> $past(host_req_i.wr))
        else $error("epp version changed without a write");
    a_freeze_mode: assert property ($past(mode_i) != 3'h3 |-> !freeze_o)
        else $error("freeze outside ecp fifo mode");
    a_tmo_cause: assert property (epp_tmo_irq_o |-> $past(epp_tmo_i))
        else $error("time-out interrupt without event");
    a_push_mode: assert property (cmd_push_o |-> $past(mode_i) == 3'h3)
        else $error("command push outside ecp fifo mode");
    a_drq_gated: assert property (!dma_en_i ##1 !dma_en_i |=> !drq_o)
        else $error("request while dma disabled");
    a_rest_min: assert property ($fell(drq_o) && dma_en_i && $past(dma_en_i) && !svc_intr_i
        |-> !drq_o [*8])
        else $error("request back before eight idle cycles");
endmodule : ecpx_regs_properties
bind ecpx_regs ecpx_regs_properties i_props (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .host_req_i(host_req_i), .host_rsp_o(host_rsp_o), .mode_i(mode_i), .dma_en_i(dma_en_i),
    .svc_intr_i(svc_intr_i), .epp_acc_i(epp_acc_i), .ecp_acc_i(ecp_acc_i),
    .epp_tmo_i(epp_tmo_i), .zws_o(zws_o), .epp_tmo_irq_o(epp_tmo_irq_o),
    .epp_v19_o(epp_v19_o), .freeze_o(freeze_o), .cmd_push_o(cmd_push_o), .drq_o(drq_o));
`default_nettype wire

// [sim/ecpx_host_model.sv]
`include "ecpx_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ecpx_host_model (
    input  wire logic                sys_clk_i,
    input  wire logic                drq_i,
    input  wire ecpx_pkg::ecpx_rsp_t rsp_i,
    output var  ecpx_pkg::ecpx_req_t req_o,
    output logic                     done_o
);
    initial req_o = '0;
    initial done_o = 1'b0;
    // grant every other cycle so a late drop never sees a stray extra transfer
    always @(negedge sys_clk_i) done_o <= drq_i && !done_o;
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(negedge sys_clk_i) req_o = '{1'b0, 1'b1, a, d};
        @(negedge sys_clk_i) req_o = '0;
    endtask : wr
    task automatic rd(input logic [10:0] a, output logic [7:0] d);
        @(negedge sys_clk_i) req_o = '{1'b1, 1'b0, a, 8'h00};
        @(negedge sys_clk_i) req_o = '0;
        d = rsp_i.valid ? rsp_i.data : 8'hxx;
    endtask : rd
    task automatic xw(input logic [2:0] ix, input logic [7:0] d);
        wr(`ECPX_A_EIR, {5'h00, ix});
        wr(`ECPX_A_EDR, d);
    endtask : xw
endmodule : ecpx_host_model
`default_nettype wire

// [sim/ecpx_regs_tb.sv]
`include "ecpx_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ecpx_regs_tb;
    logic                sys_clk_i = 1'b0;
    logic                rst_b_i = 1'b0;
    ecpx_pkg::ecpx_req_t req;
    ecpx_pkg::ecpx_rsp_t rsp;
    logic [2:0]          mode_i = 3'h0;
    logic [2:0]          acc = 3'h0;
    logic [7:0]          dcr_i = 8'h00;
    logic [7:0]          pd_i = 8'h3c;
    logic [3:0]          ctl_i = 4'ha;
    logic [4:0]          fifo_n = 5'h10;
    logic                tag_i = 1'b1, dma_en_i = 1'b0, stb_i = 1'b0;
    logic                zero_wait_state, tmo_irq, v19, frz, push, irq_oe, drq, done;
    logic                rinit, pup, cmp, irq;
    logic [4:0]          stat_i = 5'h00;
    int                  bad_count = 0, n_compared = 0, n_done = 0;
    always #4 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (done) n_done <= n_done + 1;
    ecpx_host_model i_host (.sys_clk_i(sys_clk_i), .drq_i(drq), .rsp_i(rsp), .req_o(req),
        .done_o(done));
    ecpx_regs i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .host_req_i(req),
        .host_rsp_o(rsp), .mode_i(mode_i), .dcr_stored_i(dcr_i), .data_latch_i(8'ha5),
        .pd_pins_i(pd_i), .ctl_pins_i(ctl_i), .stat_pins_i(stat_i), .fifo_tag_i(tag_i),
        .fifo_free_i(fifo_n), .fifo_valid_i(fifo_n), .dma_en_i(dma_en_i), .svc_intr_i(1'b0),
        .xfer_done_i(done), .per_byte_wr_i(1'b0), .per_cmd_stb_i(stb_i),
        .epp_acc_i(acc[2]), .ecp_acc_i(acc[1]), .epp_tmo_i(acc[0]), .core_irq_i(1'b0),
        .zws_o(zero_wait_state), .epp_tmo_irq_o(tmo_irq), .epp_v19_o(v19), .freeze_o(frz),
        .freeze_reinit_o(rinit), .cmd_push_o(push), .compat_o(cmp), .pe_pullup_o(pup),
        .pp_irq_o(irq), .pp_irq_oe_o(irq_oe), .drq_o(drq));
    task automatic close_out;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rda(input logic [10:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd(a, d);
        chk(d & m, e);
    endtask : rda
    task automatic rdx(input logic [2:0] ix, input logic [7:0] e);
        i_host.wr(`ECPX_A_EIR, {5'h00, ix});
        rda(`ECPX_A_EDR, 8'hff, e);
    endtask : rdx
    task automatic pulse(input logic [2:0] p);
        @(negedge sys_clk_i) acc = p;
        @(negedge sys_clk_i) acc = 3'h0;
    endtask : pulse
    task automatic t_regs;
        logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
        logic [7:0] mk [8] = '{8'h31, 8'h00, 8'hd8, 8'h00, 8'h77, 8'hff, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) rdx(i[2:0], rv[i]);
        for (int i = 0; i < 8; i++) begin
            i_host.xw(i[2:0], 8'hff);
            rdx(i[2:0], mk[i]);
        end
        $display("regs done");
    endtask : t_regs
    task automatic t_zws;
        i_host.xw(3'h2, 8'h08);
        pulse(3'h4);
        chk(zero_wait_state, 8'h01);
        i_host.xw(3'h2, 8'h18);
        pulse(3'h4);
        chk(zero_wait_state, 8'h00);
        chk(v19, 8'h01);
        pulse(3'h2);
        chk(zero_wait_state, 8'h01);
        i_host.xw(3'h0, 8'h01);
        pulse(3'h1);
        chk(tmo_irq, 8'h01);
        i_host.xw(3'h0, 8'h00);
        pulse(3'h1);
        chk(tmo_irq, 8'h00);
        $display("zws done");
    endtask : t_zws
    task automatic t_view;
        mode_i = `ECPX_M_CFG;
        i_host.xw(3'h5, 8'hbf);
        chk(pup, 8'h01);
        rda(`ECPX_A_CFGA, 8'hff, `ECPX_CFGA_BASE | 8'h08);
        rda(`ECPX_A_CFGB, 8'h3f, 8'h3b);
        i_host.xw(3'h5, 8'h00);
        rda(`ECPX_A_CFGA, 8'hff, `ECPX_CFGA_BASE);
        mode_i = `ECPX_M_STD;
        dcr_i = 8'h05;
        i_host.xw(3'h0, 8'h20);
        rda(`ECPX_A_DCR, 8'h0f, 8'h0a);
        i_host.xw(3'h0, 8'h00);
        rda(`ECPX_A_DCR, 8'h0f, 8'h05);
        i_host.xw(3'h2, 8'h80);
        rda(`ECPX_A_DCR, 8'h2f, 8'h2a);
        rda(`ECPX_A_DATA, 8'hff, 8'ha5);
        chk(irq_oe, 8'h00);
        chk(cmp, 8'h01);
        mode_i = `ECPX_M_BIDIR;
        stat_i = 5'h08;
        repeat (4) @(negedge sys_clk_i);
        chk(irq, 8'h01);
        rda(`ECPX_A_STAT, 8'h04, 8'h04);
        rda(`ECPX_A_STAT, 8'h04, 8'h00);
        $display("views done");
    endtask : t_view
    task automatic strobe(input logic [7:0] pd, input logic exp);
        logic seen;
        pd_i = pd;
        // let the pin synchroniser settle before the strobe
        repeat (3) @(negedge sys_clk_i);
        stb_i = 1'b1;
        @(negedge sys_clk_i) stb_i = 1'b0;
        seen = push;
        repeat (4) @(negedge sys_clk_i) seen |= push;
        chk(seen, exp);
    endtask : strobe
    task automatic t_ecp;
        mode_i = `ECPX_M_ECP;
        dcr_i = 8'h20;
        rda(`ECPX_A_AUX, 8'h80, 8'h80);
        i_host.xw(3'h2, 8'h40);
        strobe(8'h80, 1'b1);
        strobe(8'h00, 1'b0);
        i_host.xw(3'h0, 8'h10);
        repeat (2) @(negedge sys_clk_i);
        chk(frz, 8'h01);
        mode_i = `ECPX_M_STD;
        repeat (2) @(negedge sys_clk_i);
        chk(frz, 8'h00);
        mode_i = `ECPX_M_ECP;
        i_host.xw(3'h0, 8'h00);
        @(negedge sys_clk_i);
        chk(rinit, 8'h01);
        $display("ecp done");
    endtask : t_ecp
    task automatic t_dma(input logic [7:0] v, input logic [7:0] c, input int lim, input int rest);
        int k;
        int lo;
        k = 0;
        lo = 0;
        mode_i = 3'h2;
        dcr_i = 8'h00;
        i_host.xw(3'h5, c);
        i_host.xw(3'h4, v);
        n_done = 0;
        dma_en_i = 1'b1;
        while (!drq && k < 500) @(negedge sys_clk_i) k++;
        while (drq && k < 500) @(negedge sys_clk_i) k++;
        chk(n_done[7:0], lim[7:0]);
        while (!drq && k < 500) @(negedge sys_clk_i) begin
            k++;
            lo++;
        end
        chk(lo[7:0], rest[7:0]);
        dma_en_i = 1'b0;
        $display("dma done");
        if (k >= 500) begin
            bad_count++;
            close_out();
        end
    endtask : t_dma
    initial begin
        repeat (20) @(negedge sys_clk_i);
        rst_b_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        t_regs();
        t_zws();
        t_view();
        t_ecp();
        t_dma(8'h00, 8'h00, 1, 8);
        t_dma(8'h11, 8'h00, 8, 40);
        t_dma(8'h07, 8'h00, 32, 8);
        t_dma(8'h07, 8'h40, 32, 8);
        close_out();
    end
endmodule : ecpx_regs_tb
`default_nettype wire
